/* rtl/psync_defines.svh */
`ifndef PSYNC_DEFINES_SVH
`define PSYNC_DEFINES_SVH

// ----------------------------------------
// phase mode field codes
// ----------------------------------------
`define PSYNC_MODE_OFF       3'h0
`define PSYNC_MODE_MP_MASTER 3'h1
`define PSYNC_MODE_MP_SLAVE  3'h2
`define PSYNC_MODE_MO_MASTER 3'h3
`define PSYNC_MODE_MO_SLAVE  3'h4

// ----------------------------------------
// switching divider limits and reset values
// ----------------------------------------
`define PSYNC_DIV_MIN        7'h05
`define PSYNC_DIV_MAX        7'h50
`define PSYNC_DIV_RST        7'h50
`define PSYNC_SEL_RST        5'h00
`define PSYNC_ERR_W          8
`define PSYNC_GAIN_W         3

`endif

/* rtl/psync_pkg.sv */
package psync_pkg;
	// ----------------------------------------
	// pin carrier and decoded role
	// ----------------------------------------
	typedef struct packed {
		logic o;
		logic oe;
	} psync_pin_t;

	typedef enum logic [2:0] {
		PSYNC_ROLE_OFF,
		PSYNC_ROLE_MP_MASTER,
		PSYNC_ROLE_MP_SLAVE,
		PSYNC_ROLE_MO_MASTER,
		PSYNC_ROLE_MO_SLAVE
	} psync_role_t;

	typedef enum logic {
		PSYNC_ST_RUN,
		PSYNC_ST_DELAY
	} psync_state_t;
endpackage

/* rtl/psync_pin_route.sv */
`timescale 1ns/1ps
`include "psync_defines.svh"
// Operation
// - three-bit phase mode field picks multi-phase/multi-output, master/slave
// - multi-phase master drives switching clock and error amp output onto pins
// - multi-phase slave takes sync pin as clock input and locks to it
// - slaves delay their switching clock by the phase shift register value
// - multi-phase slave regulates from pin error signal scaled by slave gain
// - alternate clock select moves sync function to alternate pin, large package only
// - multi-output master drives its switching clock on the sync pin
// - multi-output slave takes sync pin as input and synchronises to it
// - bench test enable puts analog test function on the debug pin
// - five-bit select field picks the internal signal shown in bench test
// - calibration words stay write-protected always, bench test included
// - switching clock is the oscillator divided by an integer 5 to 80
module psync_pin_route (
	input  wire logic                          sys_clk,
	input  wire logic                          rst,
	input  wire logic [2:0]                    phase_mode_sel,
	input  wire logic [4:0]                    test_signal_select,
	input  wire logic                          bench_test_enable,
	input  wire logic                          alt_clock_select,
	input  wire logic                          large_package,
	input  wire logic [6:0]                    switch_divisor,
	input  wire logic [7:0]                    slave_phase_shift_reg,
	input  wire logic [`PSYNC_GAIN_W-1:0]      slave_gain_reg,
	input  wire logic [`PSYNC_ERR_W-1:0]       error_amp_word,
	input  wire logic [`PSYNC_ERR_W-1:0]       error_pin_word,
	input  wire logic [31:0]                   test_signal_bus,
	input  wire psync_pkg::psync_pin_t         gpio_sync_drive,
	input  wire psync_pkg::psync_pin_t         gpio_error_drive,
	input  wire psync_pkg::psync_pin_t         gpio_debug_drive,
	input  wire logic                          sync_clock_pin_i,
	input  wire logic                          alternate_clock_pin_i,
	input  wire logic                          cal_write_req,
	input  wire logic                          cal_write_is_cal,
	output psync_pkg::psync_pin_t              sync_clock_pin,
	output psync_pkg::psync_pin_t              alternate_clock_pin,
	output psync_pkg::psync_pin_t              error_signal_pin,
	output psync_pkg::psync_pin_t              analog_debug_pin,
	output logic                               error_out_route,
	output logic [`PSYNC_ERR_W+`PSYNC_GAIN_W-1:0] regulation_error,
	output logic                               switch_tick,
	output logic                               switch_clock,
	output psync_pkg::psync_role_t             role,
	output logic                               cal_write_allow
);
	import psync_pkg::*;

	// ----------------------------------------
	// role decode
	// ----------------------------------------
	psync_role_t role_c;
	logic        is_master;
	logic        is_slave;
	logic        use_alt;

	always_comb begin
		case (phase_mode_sel)
			`PSYNC_MODE_MP_MASTER: role_c = PSYNC_ROLE_MP_MASTER;
			`PSYNC_MODE_MP_SLAVE:  role_c = PSYNC_ROLE_MP_SLAVE;
			`PSYNC_MODE_MO_MASTER: role_c = PSYNC_ROLE_MO_MASTER;
			`PSYNC_MODE_MO_SLAVE:  role_c = PSYNC_ROLE_MO_SLAVE;
			default:               role_c = PSYNC_ROLE_OFF;
		endcase
	end

	assign is_master = (role_c == PSYNC_ROLE_MP_MASTER) || (role_c == PSYNC_ROLE_MO_MASTER);
	assign is_slave  = (role_c == PSYNC_ROLE_MP_SLAVE) || (role_c == PSYNC_ROLE_MO_SLAVE);
	// small package has no alternate pin, so the select is ignored there
	assign use_alt   = alt_clock_select & large_package;

	// ----------------------------------------
	// incoming master clock synchroniser
	// ----------------------------------------
	logic sync_s1_ff, sync_s2_ff, sync_s3_ff, sync_lvl_ff;
	logic nxt_sync_s1, nxt_sync_lvl;
	logic master_edge;

	always_comb begin
		nxt_sync_s1  = use_alt ? alternate_clock_pin_i : sync_clock_pin_i;
		// only accept a level once two stages agree
		nxt_sync_lvl = (sync_s2_ff == sync_s3_ff) ? sync_s3_ff : sync_lvl_ff;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			// pin idles at its pull-up; a low reset would fake a master edge
			sync_s1_ff  <= 1'b1;
			sync_s2_ff  <= 1'b1;
			sync_s3_ff  <= 1'b1;
			sync_lvl_ff <= 1'b1;
		end else begin
			sync_s1_ff  <= nxt_sync_s1;
			sync_s2_ff  <= sync_s1_ff;
			sync_s3_ff  <= sync_s2_ff;
			sync_lvl_ff <= nxt_sync_lvl;
		end
	end

	assign master_edge = nxt_sync_lvl & ~sync_lvl_ff;

	// ----------------------------------------
	// switching clock divider and phase lock
	// ----------------------------------------
	psync_state_t st_ff, nxt_st;
	logic [6:0]   div_cnt_ff, nxt_div_cnt;
	logic [6:0]   div_eff;
	logic [7:0]   ph_cnt_ff, nxt_ph_cnt;
	logic         tick_ff, nxt_tick;
	logic         clk_ff, nxt_clk;

	always_comb begin
		// out-of-range divisors are clamped into the legal 5..80 band
		if (switch_divisor < `PSYNC_DIV_MIN)
			div_eff = `PSYNC_DIV_MIN;
		else if (switch_divisor > `PSYNC_DIV_MAX)
			div_eff = `PSYNC_DIV_MAX;
		else
			div_eff = switch_divisor;
	end

	always_comb begin
		nxt_st      = st_ff;
		nxt_ph_cnt  = ph_cnt_ff;
		nxt_tick    = 1'b0;
		nxt_div_cnt = div_cnt_ff;
		case (st_ff)
			PSYNC_ST_RUN: begin
				if (div_cnt_ff >= div_eff - 7'h01) begin
					nxt_div_cnt = 7'h00;
					nxt_tick    = 1'b1;
				end else begin
					nxt_div_cnt = div_cnt_ff + 7'h01;
				end
				if (is_slave && master_edge) begin
					if (slave_phase_shift_reg == 8'h00) begin
						nxt_div_cnt = 7'h00;
						nxt_tick    = 1'b1;
					end else begin
						nxt_ph_cnt = slave_phase_shift_reg;
						nxt_st     = PSYNC_ST_DELAY;
					end
				end
			end
			PSYNC_ST_DELAY: begin
				// own period keeps running while the shift elapses
				nxt_div_cnt = (div_cnt_ff >= div_eff - 7'h01) ? 7'h00 : div_cnt_ff + 7'h01;
				if (!is_slave) begin
					nxt_st = PSYNC_ST_RUN;
				end else if (ph_cnt_ff == 8'h01) begin
					nxt_div_cnt = 7'h00;
					nxt_tick    = 1'b1;
					nxt_st      = PSYNC_ST_RUN;
				end else begin
					nxt_ph_cnt = ph_cnt_ff - 8'h01;
				end
			end
			default: nxt_st = PSYNC_ST_RUN;
		endcase
		nxt_clk = (nxt_div_cnt < {1'b0, div_eff[6:1]});
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_ff      <= PSYNC_ST_RUN;
			div_cnt_ff <= 7'h00;
			ph_cnt_ff  <= 8'h00;
			tick_ff    <= 1'b0;
			clk_ff     <= 1'b0;
		end else begin
			st_ff      <= nxt_st;
			div_cnt_ff <= nxt_div_cnt;
			ph_cnt_ff  <= nxt_ph_cnt;
			tick_ff    <= nxt_tick;
			clk_ff     <= nxt_clk;
		end
	end

	assign switch_tick  = tick_ff;
	assign switch_clock = clk_ff;

	// ----------------------------------------
	// pin routing and error path
	// ----------------------------------------
	psync_pin_t sync_ff, nxt_sync, alt_ff, nxt_alt, err_ff, nxt_err, dbg_ff, nxt_dbg;
	psync_role_t role_ff;
	logic        err_route_ff, nxt_err_route;
	logic        cal_allow_ff, nxt_cal_allow;
	logic [`PSYNC_ERR_W+`PSYNC_GAIN_W-1:0] reg_err_ff, nxt_reg_err;

	always_comb begin
		nxt_sync      = gpio_sync_drive;
		nxt_alt       = '{o: 1'b0, oe: 1'b0};
		nxt_err       = gpio_error_drive;
		nxt_dbg       = gpio_debug_drive;
		nxt_err_route = 1'b0;
		nxt_reg_err   = {{`PSYNC_GAIN_W{1'b0}}, error_amp_word};
		if (is_master) begin
			// master owns the clock pin; the gpio drive is overridden
			if (use_alt)
				nxt_alt = '{o: nxt_clk, oe: 1'b1};
			else
				nxt_sync = '{o: nxt_clk, oe: 1'b1};
		end else if (is_slave) begin
			if (use_alt)
				nxt_alt = '{o: 1'b0, oe: 1'b0};
			else
				nxt_sync = '{o: 1'b0, oe: 1'b0};
		end
		if (role_c == PSYNC_ROLE_MP_MASTER) begin
			nxt_err       = '{o: 1'b0, oe: 1'b1};
			nxt_err_route = 1'b1;
		end else if (role_c == PSYNC_ROLE_MP_SLAVE) begin
			nxt_err     = '{o: 1'b0, oe: 1'b0};
			// gain 0 passes the master signal unscaled
			nxt_reg_err = ({{`PSYNC_GAIN_W{1'b0}}, error_pin_word}) *
			              ({{`PSYNC_ERR_W{1'b0}}, slave_gain_reg} + 11'h001);
		end
		if (bench_test_enable)
			nxt_dbg = '{o: test_signal_bus[test_signal_select], oe: 1'b1};
		// no test or mode input reaches this term
		nxt_cal_allow = cal_write_req & ~cal_write_is_cal;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync_ff      <= '{o: 1'b0, oe: 1'b0};
			alt_ff       <= '{o: 1'b0, oe: 1'b0};
			err_ff       <= '{o: 1'b0, oe: 1'b0};
			dbg_ff       <= '{o: 1'b0, oe: 1'b0};
			err_route_ff <= 1'b0;
			reg_err_ff   <= '0;
			cal_allow_ff <= 1'b0;
			role_ff      <= PSYNC_ROLE_OFF;
		end else begin
			sync_ff      <= nxt_sync;
			alt_ff       <= nxt_alt;
			err_ff       <= nxt_err;
			dbg_ff       <= nxt_dbg;
			err_route_ff <= nxt_err_route;
			reg_err_ff   <= nxt_reg_err;
			cal_allow_ff <= nxt_cal_allow;
			role_ff      <= role_c;
		end
	end

	assign sync_clock_pin      = sync_ff;
	assign alternate_clock_pin = alt_ff;
	assign error_signal_pin    = err_ff;
	assign analog_debug_pin    = dbg_ff;
	assign error_out_route     = err_route_ff;
	assign regulation_error    = reg_err_ff;
	assign cal_write_allow     = cal_allow_ff;
	assign role                = role_ff;
endmodule

/* verification/psync_chk.sv */
`timescale 1ns/1ps
`include "psync_defines.svh"
module psync_chk (
	input wire logic                  sys_clk,
	input wire logic                  rst,
	input wire logic [2:0]            phase_mode_sel,
	input wire logic                  bench_test_enable,
	input wire logic                  alt_clock_select,
	input wire logic                  large_package,
	input wire logic [6:0]            switch_divisor,
	input wire logic [7:0]            slave_phase_shift_reg,
	input wire logic                  sync_clock_pin_i,
	input wire logic                  cal_write_req,
	input wire logic                  cal_write_is_cal,
	input wire psync_pkg::psync_pin_t sync_clock_pin,
	input wire psync_pkg::psync_pin_t alternate_clock_pin,
	input wire psync_pkg::psync_pin_t error_signal_pin,
	input wire psync_pkg::psync_pin_t analog_debug_pin,
	input wire logic                  error_out_route,
	input wire logic                  switch_tick,
	input wire logic                  switch_clock,
	input wire psync_pkg::psync_role_t role,
	input wire logic                  cal_write_allow
);
	import psync_pkg::*;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	logic altm, mpm, mps, mas, mos, own;
	assign altm = alt_clock_select & large_package;
	assign mpm = phase_mode_sel == `PSYNC_MODE_MP_MASTER;
	assign mps = phase_mode_sel == `PSYNC_MODE_MP_SLAVE;
	assign mas = mpm || phase_mode_sel == `PSYNC_MODE_MO_MASTER;
	assign mos = phase_mode_sel == `PSYNC_MODE_MO_SLAVE;
	// slaves restart the divider, so the period only holds on own clock
	assign own = !mps && !mos && switch_divisor <= `PSYNC_DIV_MIN;
	sequence s_quiet4;
		!switch_tick [*4];
	endsequence
	sequence s_own_tick;
		own [*3] ##0 switch_tick;
	endsequence
	a_role_decode: assert property (
		##1 role == ($past(phase_mode_sel) inside {[3'h1:3'h4]} ? psync_role_t'($past(phase_mode_sel)) : PSYNC_ROLE_OFF)
	) else $error("role decode wrong");
	a_master_clock: assert property (
		mas && !altm |=> sync_clock_pin.oe && sync_clock_pin.o == switch_clock
	) else $error("master clock not on sync pin");
	a_mp_error_out: assert property (
		mpm |=> error_signal_pin.oe && error_out_route
	) else $error("error amp not routed out");
	a_slave_inputs: assert property (
		mps && !altm |=> !error_signal_pin.oe && !error_out_route && !sync_clock_pin.oe
	) else $error("slave pin driven");
	a_alt_clock: assert property (
		mpm && altm |=> alternate_clock_pin.oe && alternate_clock_pin.o == switch_clock
	) else $error("alternate pin lacks clock");
	a_bench_route: assert property (
		bench_test_enable |=> analog_debug_pin.oe
	) else $error("debug pin not driven");
	a_cal_protect: assert property (
		cal_write_req && cal_write_is_cal |=> !cal_write_allow
	) else $error("calibration write allowed");
	// a slave mode or a divisor above 5 ends the own-period window, so the attempt is dropped then
	a_own_period: assert property (
		disable iff (rst || !own) s_own_tick |=> s_quiet4 ##1 switch_tick
	) else $error("switching period wrong");
	a_slave_lock: assert property (
		$rose(sync_clock_pin_i) && mos && !altm && slave_phase_shift_reg == 8'h00 |-> ##4 switch_tick
	) else $error("slave tick not locked");
endmodule
bind psync_pin_route psync_chk i_chk (.*);

/* verification/psync_master_model.sv */
`timescale 1ns/1ps
module psync_master_model #(
	parameter int HALF = 20
) (
	input  wire logic  sys_clk,
	input  wire logic  en,
	output logic       mclk,
	output logic [7:0] err_word
);
	int cnt = 0;
	initial mclk = 1'b1;
	initial err_word = 8'h00;
	// free-running while master; a released line sits at its pull-up
	always @(negedge sys_clk) begin
		cnt <= en ? (cnt + 1) % (2 * HALF) : 0;
		mclk <= en ? (cnt >= HALF) : 1'b1;
		// soft start: the error word climbs one step per period wrap, as on a timer overflow
		if (!en)
			err_word <= 8'($urandom);
		else if (cnt == 2 * HALF - 1)
			err_word <= err_word + 8'h01;
	end
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
`include "psync_defines.svh"
module testbench;
	import psync_pkg::*;
	logic sys_clk = 1'b0, rst = 1'b1, bte, alt, lpk, creq, ccal, route, tick, sclk, allow, pen, mclk, mprev;
	logic [2:0] sel, gain, pick;
	logic [4:0] tsel;
	logic [6:0] div;
	logic [7:0] shift, amp, perr;
	logic [10:0] rerr;
	logic [31:0] tbus;
	psync_pin_t gs, ge, gd, sp, ap, ep, dp;
	psync_role_t role;
	logic [2:0] own_modes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
	int n_errors = 0, samples_checked = 0, cyc = 0, last = -1, rise = -1;
	logic ownchk = 1'b0, slvchk = 1'b0;
	always #20 sys_clk = ~sys_clk;
	psync_master_model i_far (.sys_clk(sys_clk), .en(pen), .mclk(mclk), .err_word(perr));
	psync_pin_route i_dut (.sys_clk(sys_clk), .rst(rst), .phase_mode_sel(sel), .test_signal_select(tsel),
		.bench_test_enable(bte), .alt_clock_select(alt), .large_package(lpk), .switch_divisor(div),
		.slave_phase_shift_reg(shift), .slave_gain_reg(gain), .error_amp_word(amp), .error_pin_word(perr),
		.test_signal_bus(tbus), .gpio_sync_drive(gs), .gpio_error_drive(ge), .gpio_debug_drive(gd),
		.sync_clock_pin_i(sp.oe ? sp.o : mclk), .alternate_clock_pin_i(ap.oe ? ap.o : mclk),
		.cal_write_req(creq), .cal_write_is_cal(ccal), .sync_clock_pin(sp), .alternate_clock_pin(ap),
		.error_signal_pin(ep), .analog_debug_pin(dp), .error_out_route(route), .regulation_error(rerr),
		.switch_tick(tick), .switch_clock(sclk), .role(role), .cal_write_allow(allow));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("errors=%0d checks=%0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// reference model; inputs move by nonblocking writes, so old values are read here
	always @(negedge sys_clk) begin
		if (!rst) begin
			cyc++;
			chk(role, (sel inside {[3'h1:3'h4]}) ? sel : 3'h0);
			chk(rerr, (sel == 3'h2) ? perr * (gain + 1) : amp);
			chk(route, sel == 3'h1);
			chk(dp, bte ? {tbus[tsel], 1'b1} : gd);
			chk(allow, creq & ~ccal);
			if (sel == 3'h0 || sel > 3'h4) chk({sp, ep}, {gs, ge});
			if (sel == 3'h2 || sel == 3'h4) chk(sp.oe, 1'b0);
			if (sel == 3'h1 || sel == 3'h3) chk((alt & lpk) ? ap.oe : sp.oe, 1'b1);
			if (tick && ownchk && last >= 0) chk(cyc - last, 5);
			if (tick) last = cyc;
			// high for the first floor(N/2) counts of each N = 5 period
			if (ownchk && last >= 0) chk(sclk, (cyc - last) < 5 / 2);
			if (!slvchk) rise = -1;
			if (tick && rise >= 0) chk(cyc - rise, 4 + shift);
			// a lock tick that never comes is caught at its due cycle
			if (!tick && rise >= 0 && cyc - rise == 4 + shift) chk(tick, 1'b1);
			if (tick) rise = -1;
			// the pin moved at the edge before the one at which the new level is first read
			if (slvchk && mclk && !mprev) rise = cyc - 1;
		end
		mprev = mclk;
	end
	initial begin
		void'($urandom(53663));
		{sel, tsel, bte, alt, lpk, creq, ccal, shift, amp, gain, tbus, gs, ge, gd, pen} = '0;
		div = `PSYNC_DIV_MIN;
		repeat (16) @(posedge sys_clk);
		@(negedge sys_clk) rst <= 1'b0;
		ownchk <= 1'b1;
		// divisors 0..5 all clamp to the shortest period
		repeat (400) @(negedge sys_clk) begin
			pick = own_modes[$urandom % 6];
			sel <= pick;
			div <= 7'($urandom % 6);
			{alt, lpk, bte, creq, ccal} <= 5'($urandom);
			{tsel, gain, amp} <= 16'($urandom);
			tbus <= $urandom;
			// a multi-phase master has both pins set as outputs by software
			{gs, ge, gd} <= 6'($urandom) | ((pick == 3'h1) ? 6'h14 : 6'h00);
		end
		ownchk <= 1'b0;
		// long own period keeps free ticks out of the lock measurement
		for (int m = 0; m < 2; m++) begin
			// let the last values of the previous phase stand for a cycle
			@(negedge sys_clk);
			sel <= m ? `PSYNC_MODE_MO_SLAVE : `PSYNC_MODE_MP_SLAVE;
			{gs, ge} <= '0;
			shift <= m ? 8'h00 : 8'($urandom % 30 + 1);
			div <= `PSYNC_DIV_MAX;
			alt <= 1'b0;
			pen <= 1'b1;
			repeat (60) @(negedge sys_clk) {gain, amp} <= 11'($urandom);
			slvchk <= 1'b1;
			repeat (200) @(negedge sys_clk) {gain, amp} <= 11'($urandom);
			slvchk <= 1'b0;
		end
		test_done();
	end
	initial begin
		repeat (3000) @(posedge sys_clk);
		n_errors++;
		test_done();
	end
endmodule
